//--- rtl/cprv_dma_map.vh
// Register map, field positions and reset values of the preview DMA path
`ifndef CPRV_DMA_MAP_VH
`define CPRV_DMA_MAP_VH
// Register byte addresses
`define CPRV_ADDR_FRAME_BASE1 32'h4f00006c
`define CPRV_ADDR_FRAME_BASE2 32'h4f000070
`define CPRV_ADDR_FRAME_BASE3 32'h4f000074
`define CPRV_ADDR_FRAME_BASE4 32'h4f000078
`define CPRV_ADDR_TARGET_FORMAT 32'h4f00007c
`define CPRV_ADDR_DMA_CONTROL 32'h4f000080
`define CPRV_ADDR_PRESCALE_RATIO 32'h4f000084
`define CPRV_ADDR_PRESCALE_DEST 32'h4f000088
`define CPRV_ADDR_MAIN_SCALER 32'h4f00008c
`define CPRV_ADDR_TARGET_AREA 32'h4f000090
`define CPRV_ADDR_PATH_STATUS 32'h4f000098
`define CPRV_ADDR_CAPTURE_CMD 32'h4f0000a0
`define CPRV_RESET_VALUE 32'h00000000
// Target format fields
`define CPRV_TGT_WIDTH 28:16
`define CPRV_TGT_ORIENT 15:14
`define CPRV_TGT_HEIGHT 12:0
// DMA control fields
`define CPRV_CTL_MAIN_BURST 23:19
`define CPRV_CTL_TAIL_BURST 18:14
`define CPRV_CTL_FINAL_ARM 2
// Pre-scaler fields
`define CPRV_PRE_SHIFT 31:28
`define CPRV_PRE_H_RATIO 22:16
`define CPRV_PRE_V_RATIO 6:0
`define CPRV_PRE_OUT_WIDTH 27:16
`define CPRV_PRE_OUT_HEIGHT 11:0
// Main scaler and target area fields
`define CPRV_MS_SAMPLING 31
`define CPRV_MS_RGB_DEPTH 30
`define CPRV_MS_DIRECTION 29:28
`define CPRV_MS_H_RATIO 24:16
`define CPRV_MS_GO 15
`define CPRV_MS_V_RATIO 8:0
`define CPRV_AREA 25:0
// Status fields
`define CPRV_ST_CB_OVF 31
`define CPRV_ST_CR_OVF 30
`define CPRV_ST_FRAME_CNT 27:26
`define CPRV_ST_ORIENT 24:23
`define CPRV_ST_CAPTURE 21
// Capture command fields
`define CPRV_CPT_GLOBAL 31
`define CPRV_CPT_CODEC 30
`define CPRV_CPT_PREVIEW 29
// Codes
`define CPRV_ORIENT_X_MIRROR 2'b01
`define CPRV_ORIENT_Y_MIRROR 2'b10
`define CPRV_ORIENT_ROT180 2'b11
`define CPRV_DIR_DOWN 2'b00
`define CPRV_DIR_UP 2'b11
`define CPRV_RESP_OKAY 2'b00
`define CPRV_RESP_SLVERR 2'b10
`endif

//--- rtl/cprv_dma.v
// Preview path DMA: register slave, pre-scaler, RGB conversion, frame writer
//
// Design decision made here: the AXI4-Lite slave port.
`include "cprv_dma_map.vh"
module cprv_dma (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // AXI4-Lite write channels
   input wire [31:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   // AXI4-Lite read channels
   input wire [31:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   // Camera pixel stream
   input wire pixValid,
   output wire pixReady,
   input wire [7:0] pixY,
   input wire [7:0] pixCb,
   input wire [7:0] pixCr,
   input wire pixLineEnd,
   input wire pixFrameStart,
   input wire cbFifoOverflow,
   input wire crFifoOverflow,
   // Memory write port
   output reg memValid,
   input wire memReady,
   output reg [31:0] memAddr,
   output reg [31:0] memData,
   output reg memBurstStart,
   output reg [4:0] memBurstLen,
   // Frame events
   output reg frameDone,
   output reg finalIrq
);
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Byte-lane merge of a register write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = data[i*8 +: 8];
      end
   endfunction

   // Clamp a signed sum to one byte
   function [7:0] clampByte;
      input signed [11:0] v;
      begin
         if (v < 0)
            clampByte = 8'h00;
         else if (v > 255)
            clampByte = 8'hff;
         else
            clampByte = v[7:0];
      end
   endfunction

   // Next value of a decimation counter, a ratio of zero acts as one
   function [6:0] decStep;
      input [6:0] cnt;
      input [6:0] ratio;
      begin
         if (cnt + 7'h01 >= ratio)
            decStep = 7'h00;
         else
            decStep = cnt + 7'h01;
      end
   endfunction

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   reg [31:0] frameBase [0:3];
   reg [31:0] targetFormat;
   reg [31:0] dmaControl;
   reg [31:0] prescaleRatio;
   reg [31:0] prescaleDest;
   reg [31:0] mainScaler;
   reg [31:0] targetArea;
   reg [31:0] captureCmd;
   reg [31:0] awAddrHold;
   reg [31:0] wDataHold;
   reg [3:0] wStrbHold;
   reg awHeld;
   reg wHeld;
   reg [1:0] frameCount;
   reg [1:0] orientActive;
   reg [1:0] wrState;
   reg clearFinalArm;
   reg [31:0] statusWord;
   reg [31:0] readWord;
   reg readHit;
   reg writeHit;
   wire [31:0] wrAddr;
   wire [31:0] wrData;
   wire [3:0] wrStrb;
   wire doWrite;

   // Channels take one item each while no response is pending
   assign awready = !awHeld && !bvalid;
   assign wready = !wHeld && !bvalid;
   assign arready = !rvalid;
   assign wrAddr = awHeld ? awAddrHold : awaddr;
   assign wrData = wHeld ? wDataHold : wdata;
   assign wrStrb = wHeld ? wStrbHold : wstrb;
   assign doWrite = (awHeld || (awvalid && awready)) && (wHeld || (wvalid && wready));

   // Status word assembled from live state
   always @*
   begin
      statusWord = 32'h00000000;
      statusWord[`CPRV_ST_CB_OVF] = cbFifoOverflow;
      statusWord[`CPRV_ST_CR_OVF] = crFifoOverflow;
      statusWord[`CPRV_ST_FRAME_CNT] = frameCount;
      statusWord[`CPRV_ST_ORIENT] = orientActive;
      statusWord[`CPRV_ST_CAPTURE] = (wrState != 2'b00);
   end

   // Write address decode
   always @*
   begin
      case (wrAddr)
         `CPRV_ADDR_FRAME_BASE1, `CPRV_ADDR_FRAME_BASE2, `CPRV_ADDR_FRAME_BASE3,
         `CPRV_ADDR_FRAME_BASE4, `CPRV_ADDR_TARGET_FORMAT, `CPRV_ADDR_DMA_CONTROL,
         `CPRV_ADDR_PRESCALE_RATIO, `CPRV_ADDR_PRESCALE_DEST, `CPRV_ADDR_MAIN_SCALER,
         `CPRV_ADDR_TARGET_AREA, `CPRV_ADDR_CAPTURE_CMD:
            writeHit = 1'b1;
         default:
            writeHit = 1'b0;
      endcase
   end

   // Read mux
   always @*
   begin
      readHit = 1'b1;
      case (araddr)
         `CPRV_ADDR_FRAME_BASE1: readWord = frameBase[0];
         `CPRV_ADDR_FRAME_BASE2: readWord = frameBase[1];
         `CPRV_ADDR_FRAME_BASE3: readWord = frameBase[2];
         `CPRV_ADDR_FRAME_BASE4: readWord = frameBase[3];
         `CPRV_ADDR_TARGET_FORMAT: readWord = targetFormat;
         `CPRV_ADDR_DMA_CONTROL: readWord = dmaControl;
         `CPRV_ADDR_PRESCALE_RATIO: readWord = prescaleRatio;
         `CPRV_ADDR_PRESCALE_DEST: readWord = prescaleDest;
         `CPRV_ADDR_MAIN_SCALER: readWord = mainScaler;
         `CPRV_ADDR_TARGET_AREA: readWord = targetArea;
         `CPRV_ADDR_PATH_STATUS: readWord = statusWord;
         `CPRV_ADDR_CAPTURE_CMD: readWord = captureCmd;
         default:
         begin
            readWord = 32'h00000000;
            readHit = 1'b0;
         end
      endcase
   end

   // Bus slave and register storage
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frameBase[0] <= `CPRV_RESET_VALUE;
         frameBase[1] <= `CPRV_RESET_VALUE;
         frameBase[2] <= `CPRV_RESET_VALUE;
         frameBase[3] <= `CPRV_RESET_VALUE;
         targetFormat <= `CPRV_RESET_VALUE;
         dmaControl <= `CPRV_RESET_VALUE;
         prescaleRatio <= `CPRV_RESET_VALUE;
         prescaleDest <= `CPRV_RESET_VALUE;
         mainScaler <= `CPRV_RESET_VALUE;
         targetArea <= `CPRV_RESET_VALUE;
         captureCmd <= `CPRV_RESET_VALUE;
         awAddrHold <= 32'h00000000;
         wDataHold <= 32'h00000000;
         wStrbHold <= 4'h0;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `CPRV_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= `CPRV_RESP_OKAY;
         rdata <= 32'h00000000;
      end
      else
      begin
         // Hardware clears the final arm; a software write below wins
         if (clearFinalArm)
            dmaControl[`CPRV_CTL_FINAL_ARM] <= 1'b0;
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            bvalid <= 1'b1;
            bresp <= writeHit ? `CPRV_RESP_OKAY : `CPRV_RESP_SLVERR;
            case (wrAddr)
               `CPRV_ADDR_FRAME_BASE1: frameBase[0] <= merge(frameBase[0], wrData, wrStrb);
               `CPRV_ADDR_FRAME_BASE2: frameBase[1] <= merge(frameBase[1], wrData, wrStrb);
               `CPRV_ADDR_FRAME_BASE3: frameBase[2] <= merge(frameBase[2], wrData, wrStrb);
               `CPRV_ADDR_FRAME_BASE4: frameBase[3] <= merge(frameBase[3], wrData, wrStrb);
               `CPRV_ADDR_TARGET_FORMAT: targetFormat <= merge(targetFormat, wrData, wrStrb);
               `CPRV_ADDR_DMA_CONTROL: dmaControl <= merge(dmaControl, wrData, wrStrb);
               `CPRV_ADDR_PRESCALE_RATIO: prescaleRatio <= merge(prescaleRatio, wrData, wrStrb);
               `CPRV_ADDR_PRESCALE_DEST: prescaleDest <= merge(prescaleDest, wrData, wrStrb);
               `CPRV_ADDR_MAIN_SCALER: mainScaler <= merge(mainScaler, wrData, wrStrb);
               `CPRV_ADDR_TARGET_AREA: targetArea <= merge(targetArea, wrData, wrStrb);
               `CPRV_ADDR_CAPTURE_CMD: captureCmd <= merge(captureCmd, wrData, wrStrb);
               default: ;
            endcase
         end
         else
         begin
            if (awvalid && awready)
            begin
               awHeld <= 1'b1;
               awAddrHold <= awaddr;
            end
            if (wvalid && wready)
            begin
               wHeld <= 1'b1;
               wDataHold <= wdata;
               wStrbHold <= wstrb;
            end
         end
         if (bvalid && bready)
            bvalid <= 1'b0;
         // Read answers one cycle after the address is taken
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= readHit ? `CPRV_RESP_OKAY : `CPRV_RESP_SLVERR;
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Configuration decode
   // ---------------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_WAIT = 2'b01;
   localparam ST_RUN = 2'b10;

   wire [12:0] tgtWidth = targetFormat[`CPRV_TGT_WIDTH];
   wire [12:0] tgtHeight = targetFormat[`CPRV_TGT_HEIGHT];
   wire [4:0] mainBurst = dmaControl[`CPRV_CTL_MAIN_BURST];
   wire [4:0] tailBurst = dmaControl[`CPRV_CTL_TAIL_BURST];
   wire [3:0] preShift = prescaleRatio[`CPRV_PRE_SHIFT];
   wire [6:0] preHRatio = prescaleRatio[`CPRV_PRE_H_RATIO];
   wire [6:0] preVRatio = prescaleRatio[`CPRV_PRE_V_RATIO];
   wire [11:0] preOutWidth = prescaleDest[`CPRV_PRE_OUT_WIDTH];
   wire sampling = mainScaler[`CPRV_MS_SAMPLING];
   wire rgbDeep = mainScaler[`CPRV_MS_RGB_DEPTH];
   wire [1:0] scaleDir = mainScaler[`CPRV_MS_DIRECTION];
   wire [8:0] mainHRatio = mainScaler[`CPRV_MS_H_RATIO];
   wire [8:0] mainVRatio = mainScaler[`CPRV_MS_V_RATIO];
   // Capture runs only with global, preview enable and scaler go all set
   wire captureOn = captureCmd[`CPRV_CPT_GLOBAL] && captureCmd[`CPRV_CPT_PREVIEW]
      && mainScaler[`CPRV_MS_GO];
   wire [12:0] lineWords = rgbDeep ? tgtWidth : {1'b0, tgtWidth[12:1]};
   wire [14:0] lineBytes = {lineWords, 2'b00};

   // ---------------------------------------------
   // Pre-scaler and colour conversion
   // ---------------------------------------------
   reg [6:0] hDec;
   reg [6:0] vDec;
   reg [11:0] preCol;
   reg [7:0] heldCb;
   reg [7:0] heldCr;
   reg [23:0] rgb;
   reg [12:0] row;
   reg [12:0] word;
   reg halfFull;
   reg [15:0] halfPix;
   reg [4:0] burstLeft;
   reg [31:0] rowBase;
   wire pixTake = pixValid && pixReady;
   // Keep one pixel per ratio step; a pixel past the output width is dropped
   wire keepPix = (vDec == 7'h00) && (hDec == 7'h00) &&
      (preOutWidth == 12'h000 || preCol < preOutWidth);
   wire [7:0] useCb = sampling ? pixCb : heldCb;
   wire [7:0] useCr = sampling ? pixCr : heldCr;
   wire signed [11:0] sY = {4'h0, pixY};
   wire signed [11:0] sCb = {4'h0, useCb} - 12'sd128;
   wire signed [11:0] sCr = {4'h0, useCr} - 12'sd128;
   wire xMirror = orientActive[0];
   wire yMirror = orientActive[1];
   wire lastWord = (word + 13'h0001 >= lineWords);
   wire lastRow = (row + 13'h0001 >= tgtHeight);
   wire wordReady = rgbDeep || halfFull;
   wire [15:0] pix16 = {rgb[23:19], rgb[15:10], rgb[7:3]};

   // Fixed-point YCbCr to RGB with shift-add coefficients
   always @*
   begin
      rgb[23:16] = clampByte(sY + sCr + (sCr >>> 2) + (sCr >>> 3));
      rgb[15:8] = clampByte(sY - (sCb >>> 2) - (sCb >>> 4) - (sCb >>> 5)
         - (sCr >>> 1) - (sCr >>> 3) - (sCr >>> 4));
      rgb[7:0] = clampByte(sY + sCb + (sCb >>> 1) + (sCb >>> 2));
   end

   // Row start address with vertical mirroring
   always @*
   begin
      if (xMirror)
         rowBase = frameBase[frameCount] + (tgtHeight - 13'h0001 - row) * lineBytes;
      else
         rowBase = frameBase[frameCount] + row * lineBytes;
   end

   // Pixels are taken while the word register is free or draining
   assign pixReady = !memValid || memReady;

   // ---------------------------------------------
   // Frame writer
   // ---------------------------------------------
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wrState <= ST_IDLE;
         hDec <= 7'h00;
         vDec <= 7'h00;
         preCol <= 12'h000;
         heldCb <= 8'h00;
         heldCr <= 8'h00;
         row <= 13'h0000;
         word <= 13'h0000;
         halfFull <= 1'b0;
         halfPix <= 16'h0000;
         burstLeft <= 5'h00;
         frameCount <= 2'b00;
         orientActive <= 2'b00;
         memValid <= 1'b0;
         memAddr <= 32'h00000000;
         memData <= 32'h00000000;
         memBurstStart <= 1'b0;
         memBurstLen <= 5'h00;
         frameDone <= 1'b0;
         finalIrq <= 1'b0;
         clearFinalArm <= 1'b0;
      end
      else
      begin
         frameDone <= 1'b0;
         finalIrq <= 1'b0;
         clearFinalArm <= 1'b0;
         if (memValid && memReady)
            memValid <= 1'b0;
         case (wrState)
            ST_IDLE:
            begin
               if (captureOn)
                  wrState <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (!captureOn)
                  wrState <= ST_IDLE;
               else if (pixTake && pixFrameStart)
               begin
                  wrState <= ST_RUN;
                  orientActive <= targetFormat[`CPRV_TGT_ORIENT];
                  row <= 13'h0000;
                  word <= 13'h0000;
                  halfFull <= 1'b0;
                  burstLeft <= 5'h00;
                  hDec <= 7'h00;
                  vDec <= 7'h00;
                  preCol <= 12'h000;
               end
            end
            ST_RUN:
            begin
               if (pixTake)
               begin
                  heldCb <= pixCb;
                  heldCr <= pixCr;
                  hDec <= pixLineEnd ? 7'h00 : decStep(hDec, preHRatio);
                  preCol <= pixLineEnd ? 12'h000 : preCol + {11'h000, keepPix};
                  if (pixLineEnd)
                     vDec <= decStep(vDec, preVRatio);
                  if (keepPix && !rgbDeep && !halfFull)
                  begin
                     halfPix <= pix16;
                     halfFull <= 1'b1;
                  end
                  else if (keepPix)
                  begin
                     halfFull <= 1'b0;
                     memValid <= 1'b1;
                     if (rgbDeep)
                        memData <= {8'h00, rgb};
                     else if (yMirror)
                        memData <= {halfPix, pix16};
                     else
                        memData <= {pix16, halfPix};
                     if (yMirror)
                        memAddr <= rowBase + {17'h00000, lineBytes - {word, 2'b00} - 15'h0004};
                     else
                        memAddr <= rowBase + {17'h00000, word, 2'b00};
                     // Bulk of the line in main bursts, the rest in a tail burst
                     memBurstStart <= (burstLeft == 5'h00);
                     if (burstLeft == 5'h00)
                     begin
                        if ({3'b000, lineWords - word} > {11'h000, mainBurst})
                        begin
                           memBurstLen <= mainBurst;
                           burstLeft <= mainBurst - 5'h01;
                        end
                        else
                        begin
                           memBurstLen <= tailBurst;
                           burstLeft <= tailBurst - 5'h01;
                        end
                     end
                     else
                        burstLeft <= burstLeft - 5'h01;
                     if (lastWord)
                     begin
                        word <= 13'h0000;
                        burstLeft <= 5'h00;
                        row <= row + 13'h0001;
                        if (lastRow)
                        begin
                           // Frame complete: advance buffer, raise events
                           frameCount <= frameCount + 2'b01;
                           frameDone <= 1'b1;
                           finalIrq <= dmaControl[`CPRV_CTL_FINAL_ARM];
                           clearFinalArm <= dmaControl[`CPRV_CTL_FINAL_ARM];
                           wrState <= captureOn ? ST_WAIT : ST_IDLE;
                        end
                     end
                     else
                        word <= word + 13'h0001;
                  end
               end
            end
            default:
               wrState <= ST_IDLE;
         endcase
      end
   end
endmodule

//--- test/cprv_mem_model.sv
// Memory side of the preview writer, with random stalls
module cprv_mem_model (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Write port
   input wire memValid,
   output logic memReady,
   input wire [31:0] memAddr,
   input wire [31:0] memData,
   input wire memBurstStart,
   input wire [4:0] memBurstLen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] addrQ[$];
   logic [31:0] dataQ[$];
   logic [4:0] lenQ[$];
   // Record each accepted beat, then stall at random
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         memReady <= 1'b0;
      else
      begin
         if (memValid && memReady)
         begin
            addrQ.push_back(memAddr);
            dataQ.push_back(memData);
            lenQ.push_back(memBurstStart ? memBurstLen : 5'h00);
         end
         memReady <= ($urandom % 3) != 0;
      end
   end
endmodule

//--- test/cprv_dma_monitor.sv
// Port checks of the preview DMA path
module cprv_dma_monitor (
   // Clock and reset
   input wire ref_clk,
   input wire reset_n,
   // Register bus
   input wire arvalid,
   input wire arready,
   input wire rvalid,
   input wire rready,
   input wire [31:0] rdata,
   input wire bvalid,
   input wire bready,
   input wire [1:0] bresp,
   // Pixel and memory side
   input wire pixReady,
   input wire memValid,
   input wire memReady,
   input wire [31:0] memAddr,
   input wire [31:0] memData,
   input wire memBurstStart,
   input wire [4:0] memBurstLen,
   input wire frameDone,
   input wire finalIrq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence memStall;
      memValid && !memReady;
   endsequence
   a_mem_hold: assert property (memStall |=> memValid && $stable(memAddr) && $stable(memData))
      else $error("memory beat changed while stalled");
   a_pix_stall: assert property (memStall |-> !pixReady)
      else $error("pixel taken while memory stalled");
   a_burst_len: assert property (memValid && memBurstStart |-> memBurstLen inside {2, 4, 8, 16})
      else $error("bad burst length");
   a_irq_done: assert property (finalIrq |-> frameDone)
      else $error("final pulse outside frame end");
   a_done_pulse: assert property (frameDone |=> !frameDone)
      else $error("frame end longer than one cycle");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
endmodule
bind cprv_dma cprv_dma_monitor cprv_dma_monitor_inst (.*);

//--- test/testbench.sv
// Self-checking bench of the preview DMA path
`include "cprv_dma_map.vh"
`define CHK(n, e, s) check(n, e, s)
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1, pixValid = 1'b0, pixLineEnd = 1'b0;
   logic pixFrameStart = 1'b0, cbFifoOverflow = 1'b0, crFifoOverflow = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pixReady, memValid, memReady;
   logic memBurstStart, frameDone, finalIrq;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, memAddr, memData;
   logic [7:0] pixY = 8'h00, pixCb = 8'h80, pixCr = 8'h80;
   logic [4:0] memBurstLen;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   int errors = 0, comparisons = 0, doneCnt = 0, irqCnt = 0, cnt = 0;
   logic [7:0] ys[$];
   logic [31:0] bases[4];
   cprv_dma cprv_dma_inst (.*);
   cprv_mem_model cprv_mem_model_inst (.*);
   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Frame event counters
   always @(posedge ref_clk)
   begin
      doneCnt <= doneCnt + int'(frameDone);
      irqCnt <= irqCnt + int'(finalIrq);
   end
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #200000;
      errors++;
      end_of_test;
   end
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er = `CPRV_RESP_OKAY);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      `CHK("bresp", er, bresp);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] v,
      input logic [1:0] er = `CPRV_RESP_OKAY);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      v = rdata;
      `CHK("rresp", er, rresp);
   endtask
   task automatic pix(input logic fs, le);
      pixY <= 8'($urandom);
      pixFrameStart <= fs;
      pixLineEnd <= le;
      pixValid <= 1'b1;
      do
         @(posedge ref_clk);
      while (!pixReady);
      ys.push_back(pixY);
   endtask
   function automatic logic [15:0] c(input logic [7:0] y);
      return {y[7:3], y[7:2], y[7:3]};
   endfunction
   // One line frame of six words; g selects the global enable
   task automatic frame(input logic [1:0] o, input logic dep, arm, g);
      logic [31:0] v, e, aq[$], dq[$];
      logic [4:0] lq[$];
      logic [7:0] a, b;
      int s, p, d0, i0, n;
      n = dep ? 6 : 12;
      cprv_mem_model_inst.addrQ.delete();
      cprv_mem_model_inst.dataQ.delete();
      cprv_mem_model_inst.lenQ.delete();
      ys.delete();
      cbFifoOverflow <= 1'($urandom);
      crFifoOverflow <= 1'($urandom);
      wr(`CPRV_ADDR_TARGET_FORMAT, (n << 16) | (o << 14) | 1);
      wr(`CPRV_ADDR_DMA_CONTROL, (4 << 19) | (2 << 14) | (arm << 2));
      wr(`CPRV_ADDR_MAIN_SCALER, 32'hb0008000 | (dep << 30));
      wr(`CPRV_ADDR_TARGET_AREA, n);
      wr(`CPRV_ADDR_CAPTURE_CMD, g ? 32'ha0000000 : 32'h20000000);
      d0 = doneCnt;
      i0 = irqCnt;
      pix(1'b1, 1'b0);
      repeat (n - 1)
         pix(1'b0, 1'b0);
      pix(1'b0, 1'b1);
      pixValid <= 1'b0;
      void'(ys.pop_front());
      for (int k = 0; k < 300 && cprv_mem_model_inst.addrQ.size() < 6; k++)
         @(posedge ref_clk);
      repeat (3)
         @(posedge ref_clk);
      aq = cprv_mem_model_inst.addrQ;
      dq = cprv_mem_model_inst.dataQ;
      lq = cprv_mem_model_inst.lenQ;
      `CHK("beats", g ? 6 : 0, aq.size());
      `CHK("frameDone", d0 + g, doneCnt);
      `CHK("finalIrq", i0 + (arm & g), irqCnt);
      foreach (aq[k])
      begin
         s = int'((aq[k] - bases[cnt]) >> 2);
         p = o[1] ? 5 - s : s;
         `CHK("slot", 1, s < 6);
         a = dep ? ys[p] : ys[2 * p];
         b = ys[2 * p + 1];
         e = dep ? {8'h00, a, a, a} : o[1] ? {c(a), c(b)} : {c(b), c(a)};
         `CHK("memData", e, dq[k]);
         `CHK("burstLen", k == 0 ? 4 : k == 4 ? 2 : 0, lq[k]);
      end
      if (g)
         cnt = (cnt + 1) % 4;
      rd(`CPRV_ADDR_PATH_STATUS, v);
      `CHK("frameCount", cnt, v[27:26]);
      `CHK("orientation", o, v[24:23]);
      `CHK("captureOn", g, v[21]);
      `CHK("overflow", {cbFifoOverflow, crFifoOverflow}, v[31:30]);
      rd(`CPRV_ADDR_DMA_CONTROL, v);
      `CHK("finalArm", 0, v[2]);
   endtask
   // Main sequence
   initial
   begin
      logic [31:0] v, m;
      logic [31:0] rw[10] = '{`CPRV_ADDR_FRAME_BASE1, `CPRV_ADDR_FRAME_BASE2,
         `CPRV_ADDR_FRAME_BASE3, `CPRV_ADDR_FRAME_BASE4, `CPRV_ADDR_TARGET_FORMAT,
         `CPRV_ADDR_DMA_CONTROL, `CPRV_ADDR_PRESCALE_RATIO, `CPRV_ADDR_PRESCALE_DEST,
         `CPRV_ADDR_MAIN_SCALER, `CPRV_ADDR_TARGET_AREA};
      logic [31:0] mk[10] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
         32'h1fffdfff, 32'h00ffc004, 32'hf07f007f, 32'h0fff0fff, 32'hf1ff81ff, 32'h03ffffff};
      v = $urandom(32'h09a5);
      repeat (5)
         @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      // Reset values and field read-back
      foreach (rw[i])
      begin
         rd(rw[i], v);
         `CHK("resetValue", `CPRV_RESET_VALUE, v);
         m = $urandom & mk[i];
         wr(rw[i], m);
         rd(rw[i], v);
         `CHK("readBack", m, v);
      end
      rd(`CPRV_ADDR_CAPTURE_CMD, v);
      `CHK("resetValue", `CPRV_RESET_VALUE, v);
      rd(`CPRV_ADDR_PATH_STATUS, v);
      `CHK("resetValue", `CPRV_RESET_VALUE, v);
      wr(`CPRV_ADDR_PATH_STATUS, 32'hffffffff, `CPRV_RESP_SLVERR);
      rd(32'h4f0000a4, v, `CPRV_RESP_SLVERR);
      `CHK("unmapped", 0, v);
      // Frame buffers and a pass-through pre-scaler
      foreach (bases[i])
      begin
         bases[i] = {i[1:0], 30'h0} | ($urandom & 32'h0fff0000);
         wr(rw[i], bases[i]);
      end
      wr(`CPRV_ADDR_PRESCALE_RATIO, 0);
      wr(`CPRV_ADDR_PRESCALE_DEST, 0);
      for (int o = 0; o < 4; o++)
         frame(o[1:0], 1'b1, o == 2, 1'b1);
      frame(2'b00, 1'b0, 1'b1, 1'b1);
      frame(2'b00, 1'b1, 1'b0, 1'b0);
      end_of_test;
   end
endmodule
